// File: src/bbc_consts.svh
// constants for the buck-boost bridge sequencer: mode codes, timing, bridge dead time
// assumes a 125 MHz clock; all counts derived from printed times
`ifndef BBC_CONSTS_SVH
`define BBC_CONSTS_SVH
`define BBC_CLK_MHZ          125
`define BBC_DEB_LONG_MS      1300
`define BBC_DEB_SHORT_MS     150
`define BBC_DEB_LONG_CYC     (`BBC_DEB_LONG_MS * `BBC_CLK_MHZ * 1000)
`define BBC_DEB_SHORT_CYC    (`BBC_DEB_SHORT_MS * `BBC_CLK_MHZ * 1000)
`define BBC_SETTLE_US        40
`define BBC_SETTLE_CYC       (`BBC_SETTLE_US * `BBC_CLK_MHZ)
`define BBC_DEAD_NS          24
`define BBC_DEAD_CYC         ((`BBC_DEAD_NS * `BBC_CLK_MHZ + 999) / 1000)
`define BBC_MODE_OFF         3'h0
`define BBC_MODE_BOOST       3'h1
`define BBC_MODE_BUCK        3'h2
`define BBC_MODE_BB          3'h3
`define BBC_MODE_RBOOST      3'h5
`define BBC_MODE_RBUCK       3'h6
`define BBC_MODE_RBB         3'h7
`endif

// File: src/bbc_pkg.sv
// types for the buck-boost bridge sequencer
// used only by bbc_bridge_ctrl
package bbc_pkg;
  typedef enum logic [2:0] {
    SS_IDLE   = 3'b000,
    SS_DEB    = 3'b001,
    SS_CONFIG_RESISTOR_PIN   = 3'b010,
    SS_RAMP   = 3'b011,
    SS_READY  = 3'b100
  } bbc_ss_t;
  typedef enum logic [2:0] {
    PH_A    = 3'b000,
    PH_DA   = 3'b001,
    PH_B    = 3'b010,
    PH_DB   = 3'b011,
    PH_C    = 3'b100,
    PH_DC   = 3'b101
  } bbc_ph_t;
endpackage : bbc_pkg

// File: src/bbc_bridge_ctrl.sv
// bridge gate sequencer, mode selection and adapter soft-start for a buck-boost charger
// assumes analog comparators deliver clean levels synchronous to clk; no input synchronisers here
`include "bbc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - buck: input pair switches, output high on
// - boost: output pair switches, input high on
// - buck-boost: three-step sequence of both pairs
// - reverse buck: output pair switches, input high
// - reverse boost: input pair switches, output high
// - reverse buck-boost: mirrored three-step sequence
// - rising above 94 percent: boost to buck-boost
// - above 120 percent forces buck, or reverse boost when reverse is enabled
// - falling below 106 percent: buck to buck-boost
// - falling below 80 percent: buck-boost to boost
// - reverse needs command, pin, battery above threshold
// - no reverse mode for single-cell packs
// - turbo turns battery path gate on
// - logic runs only with bias above threshold
// - debounce adapter, long or short by bit
// - first insertion after reset uses short debounce
// - block switch on during input short
// - release present flag when all three good
// - flag after switch, hold low without adapter
// - read config resistor before switch on
// - pulse ends at window, restarts at error level
// - diode emulation cuts low side at zero
// - report bridge mode as three-bit code
module bbc_bridge_ctrl #(
  parameter int unsigned DEB_LONG_CYC  = `BBC_DEB_LONG_CYC,   // long debounce in cycles
  parameter int unsigned DEB_SHORT_CYC = `BBC_DEB_SHORT_CYC,  // short debounce in cycles
  parameter int unsigned SETTLE_CYC    = `BBC_SETTLE_CYC,     // config pin settle time
  parameter int unsigned DEAD_CYC      = `BBC_DEAD_CYC        // non-overlap time
) (
  input  wire logic       clk,                        // 125 MHz clock
  input  wire logic       rst_b,                      // async reset, active low
  input  wire logic       bias_above_2v7,             // bias supply above digital threshold
  input  wire logic       bias_above_3v8,             // bias supply above flag threshold
  input  wire logic       adapter_above_3v2,          // adapter voltage above start level
  input  wire logic       adapter_sense_input_ok,     // sense input above 0.8 V
  input  wire logic       input_sense_node_ok,        // sense node above 2 V
  input  wire logic       long_debounce_sel,          // config bit: long debounce
  input  wire logic       adapter_switch_on_done,     // adapter switch fully enhanced
  input  wire logic [4:0] config_code_in,             // digitised config resistor reading
  input  wire logic       adp_gt_94,                  // adapter above 94 percent of rail
  input  wire logic       adp_gt_120,                 // adapter above 120 percent of rail
  input  wire logic       adp_lt_106,                 // adapter below 106 percent of rail
  input  wire logic       adp_lt_80,                  // adapter below 80 percent of rail
  input  wire logic       reverse_cmd_en,             // host command enables reverse
  input  wire logic       reverse_power_enable_pin,   // reverse enable pin
  input  wire logic       battery_above_5v2,          // battery above reverse threshold
  input  wire logic       single_cell,                // configured for one cell
  input  wire logic       turbo_event,                // turbo demand level
  input  wire logic       ripple_at_window,           // ripple cap at upper window level
  input  wire logic       ripple_at_comp,             // ripple cap back at error amp level
  input  wire logic       diode_emulation,            // diode emulation enable
  input  wire logic       phase_zero,                 // phase node reached zero
  output logic            adapter_switch_gate,        // adapter switch drive
  output logic            config_current_en,          // source current out of config pin
  output logic [4:0]      config_code,                // latched config resistor code
  output logic            adapter_present_flag_o,     // flag pin drive value (always low)
  output logic            adapter_present_flag_oe,    // flag pin pull-low enable
  output logic            battery_path_gate,          // battery path gate drive
  output logic            input_high_side_fet,        // gate drive
  output logic            input_low_side_fet,         // gate drive
  output logic            output_low_side_fet,        // gate drive
  output logic            output_high_side_fet,       // gate drive
  output logic [2:0]      bridge_mode                 // present mode code
);

  // ****************************************
  // parameter checks
  // ****************************************
  initial begin
    if (DEB_SHORT_CYC < 1 || DEB_LONG_CYC < 1 || SETTLE_CYC < 1 || DEAD_CYC < 1) begin
      $error("bbc_bridge_ctrl: counts must be at least one");
    end
  end

  // ****************************************
  // soft-start sequencer
  // ****************************************
  bbc_pkg::bbc_ss_t ss_q;
  logic [31:0]      ss_cnt_q;
  logic             first_ins_q;
  logic             run;
  logic             pulse_q;
  logic [31:0]      deb_len;

  assign run = bias_above_2v7;
  assign deb_len = (first_ins_q || !long_debounce_sel) ? DEB_SHORT_CYC : DEB_LONG_CYC;

  // sequence: debounce with short check, read config pin, ramp switch, ready
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ss_q     <= bbc_pkg::SS_IDLE;
      ss_cnt_q <= 32'h0;
    end else if (!run || !adapter_above_3v2) begin
      ss_q     <= bbc_pkg::SS_IDLE;
      ss_cnt_q <= 32'h0;
    end else begin
      unique case (ss_q)
        bbc_pkg::SS_IDLE: begin
          ss_q     <= bbc_pkg::SS_DEB;
          ss_cnt_q <= 32'h0;
        end
        bbc_pkg::SS_DEB: begin
          if (!input_sense_node_ok || !adapter_sense_input_ok) begin
            ss_cnt_q <= 32'h0;
          end else if (ss_cnt_q + 32'h1 >= deb_len) begin
            ss_q     <= bbc_pkg::SS_CONFIG_RESISTOR_PIN;
            ss_cnt_q <= 32'h0;
          end else begin
            ss_cnt_q <= ss_cnt_q + 32'h1;
          end
        end
        bbc_pkg::SS_CONFIG_RESISTOR_PIN: begin
          if (ss_cnt_q + 32'h1 >= SETTLE_CYC) begin
            ss_q     <= bbc_pkg::SS_RAMP;
            ss_cnt_q <= 32'h0;
          end else begin
            ss_cnt_q <= ss_cnt_q + 32'h1;
          end
        end
        bbc_pkg::SS_RAMP: begin
          if (adapter_switch_on_done) begin
            ss_q <= bbc_pkg::SS_READY;
          end
        end
        bbc_pkg::SS_READY: begin
          ss_q <= bbc_pkg::SS_READY;
        end
        default: begin
          ss_q <= bbc_pkg::SS_IDLE;
        end
      endcase
    end
  end

  // first insertion tracked from bias reset; cleared once debounce finishes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_ins_q <= 1'b1;
    end else if (!run) begin
      first_ins_q <= 1'b1;
    end else if (ss_q == bbc_pkg::SS_CONFIG_RESISTOR_PIN) begin
      first_ins_q <= 1'b0;
    end
  end

  // latch reading at end of settle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      config_code <= 5'h00;
    end else if (ss_q == bbc_pkg::SS_CONFIG_RESISTOR_PIN && ss_cnt_q + 32'h1 >= SETTLE_CYC) begin
      config_code <= config_code_in;
    end
  end

  assign config_current_en   = (ss_q == bbc_pkg::SS_CONFIG_RESISTOR_PIN);
  assign adapter_switch_gate = (ss_q == bbc_pkg::SS_RAMP) || (ss_q == bbc_pkg::SS_READY);

  logic flag_release;
  assign flag_release = run && bias_above_3v8 && adapter_sense_input_ok && (ss_q == bbc_pkg::SS_READY);
  assign adapter_present_flag_o  = 1'b0;
  assign adapter_present_flag_oe = !flag_release;

  // ****************************************
  // mode selection
  // ****************************************
  logic [2:0] mode_q;
  logic       rev_ok;
  logic [2:0] fwd_mode;

  assign rev_ok = reverse_cmd_en && reverse_power_enable_pin && battery_above_5v2 && !single_cell;

  // forward hysteresis; reverse mode picked from the same ratio comparators
  always_comb begin
    fwd_mode = mode_q;
    if (adp_gt_120) begin
      fwd_mode = `BBC_MODE_BUCK;
    end else begin
      unique case (mode_q)
        `BBC_MODE_BOOST, `BBC_MODE_RBUCK: begin
          if (adp_gt_94) fwd_mode = `BBC_MODE_BB;
          else           fwd_mode = `BBC_MODE_BOOST;
        end
        `BBC_MODE_BUCK, `BBC_MODE_RBOOST: begin
          if (adp_lt_106) fwd_mode = `BBC_MODE_BB;
          else            fwd_mode = `BBC_MODE_BUCK;
        end
        `BBC_MODE_BB, `BBC_MODE_RBB: begin
          if (adp_lt_80) fwd_mode = `BBC_MODE_BOOST;
          else           fwd_mode = `BBC_MODE_BB;
        end
        default: begin
          fwd_mode = adp_lt_80 ? `BBC_MODE_BOOST : `BBC_MODE_BB;
        end
      endcase
    end
  end

  // mode code; reverse sets the top bit, boost/buck swap roles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= `BBC_MODE_OFF;
    end else if (rev_ok && run) begin
      unique case (fwd_mode)
        `BBC_MODE_BOOST: mode_q <= `BBC_MODE_RBUCK;
        `BBC_MODE_BUCK:  mode_q <= `BBC_MODE_RBOOST;
        default:         mode_q <= `BBC_MODE_RBB;
      endcase
    end else if (adapter_present_flag_oe) begin
      mode_q <= `BBC_MODE_OFF;
    end else begin
      mode_q <= fwd_mode;
    end
  end
  assign bridge_mode = mode_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      battery_path_gate <= 1'b0;
    end else begin
      battery_path_gate <= run && turbo_event;
    end
  end

  // ****************************************
  // ripple modulator and phase stepping
  // ****************************************
  // pulse window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_q <= 1'b0;
    end else if (mode_q == `BBC_MODE_OFF) begin
      pulse_q <= 1'b0;
    end else if (pulse_q && ripple_at_window) begin
      pulse_q <= 1'b0;
    end else if (!pulse_q && ripple_at_comp) begin
      pulse_q <= 1'b1;
    end
  end

  // phases: A = both on-pulse FETs, B = middle step, C = both sync; D* = dead time
  bbc_pkg::bbc_ph_t ph_q;
  logic [15:0]      dead_q;
  logic             dead_done;
  logic             pulse_d1_q;
  logic             de_off_q;
  assign dead_done = (dead_q + 16'h1 >= DEAD_CYC[15:0]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_d1_q <= 1'b0;
    end else begin
      pulse_d1_q <= pulse_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_q   <= bbc_pkg::PH_DC;
      dead_q <= 16'h0;
    end else if (mode_q == `BBC_MODE_OFF) begin
      ph_q   <= bbc_pkg::PH_DC;
      dead_q <= 16'h0;
    end else begin
      unique case (ph_q)
        bbc_pkg::PH_A: if (!pulse_q) begin
          ph_q   <= bbc_pkg::PH_DA;
          dead_q <= 16'h0;
        end
        bbc_pkg::PH_DA: if (dead_done) ph_q <= bbc_pkg::PH_B;
                        else dead_q <= dead_q + 16'h1;
        bbc_pkg::PH_B: begin
          // middle step lasts one cycle; swap the other pair next
          ph_q   <= bbc_pkg::PH_DB;
          dead_q <= 16'h0;
        end
        bbc_pkg::PH_DB: if (dead_done) ph_q <= bbc_pkg::PH_C;
                        else dead_q <= dead_q + 16'h1;
        bbc_pkg::PH_C: if (pulse_q && !pulse_d1_q) begin
          ph_q   <= bbc_pkg::PH_DC;
          dead_q <= 16'h0;
        end
        bbc_pkg::PH_DC: if (dead_done && pulse_q) ph_q <= bbc_pkg::PH_A;
                        else if (!dead_done) dead_q <= dead_q + 16'h1;
        default: ph_q <= bbc_pkg::PH_DC;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      de_off_q <= 1'b0;
    end else if (diode_emulation && phase_zero) begin
      de_off_q <= 1'b1;
    end else if (ph_q == bbc_pkg::PH_DC) begin
      de_off_q <= 1'b0;
    end
  end

  // gate decode per mode; dead phases drop only the pair being swapped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      input_high_side_fet  <= 1'b0;
      input_low_side_fet   <= 1'b0;
      output_low_side_fet  <= 1'b0;
      output_high_side_fet <= 1'b0;
    end else begin
      input_high_side_fet  <= 1'b0;
      input_low_side_fet   <= 1'b0;
      output_low_side_fet  <= 1'b0;
      output_high_side_fet <= 1'b0;
      unique case (mode_q)
        `BBC_MODE_BUCK, `BBC_MODE_RBOOST: begin
          output_high_side_fet <= 1'b1;
          input_high_side_fet  <= (ph_q == bbc_pkg::PH_A);
          input_low_side_fet   <= (ph_q == bbc_pkg::PH_B || ph_q == bbc_pkg::PH_C) && !de_off_q;
        end
        `BBC_MODE_BOOST, `BBC_MODE_RBUCK: begin
          input_high_side_fet  <= 1'b1;
          output_low_side_fet  <= (ph_q == bbc_pkg::PH_A) && !de_off_q;
          output_high_side_fet <= (ph_q == bbc_pkg::PH_B || ph_q == bbc_pkg::PH_C);
        end
        `BBC_MODE_BB: begin
          input_high_side_fet  <= (ph_q == bbc_pkg::PH_A || ph_q == bbc_pkg::PH_DA || ph_q == bbc_pkg::PH_B);
          output_low_side_fet  <= (ph_q == bbc_pkg::PH_A);
          output_high_side_fet <= (ph_q == bbc_pkg::PH_B || ph_q == bbc_pkg::PH_DB || ph_q == bbc_pkg::PH_C);
          input_low_side_fet   <= (ph_q == bbc_pkg::PH_C) && !de_off_q;
        end
        `BBC_MODE_RBB: begin
          output_high_side_fet <= (ph_q == bbc_pkg::PH_A || ph_q == bbc_pkg::PH_DA || ph_q == bbc_pkg::PH_B);
          input_low_side_fet   <= (ph_q == bbc_pkg::PH_A);
          input_high_side_fet  <= (ph_q == bbc_pkg::PH_B || ph_q == bbc_pkg::PH_DB || ph_q == bbc_pkg::PH_C);
          output_low_side_fet  <= (ph_q == bbc_pkg::PH_C) && !de_off_q;
        end
        default: begin
          input_high_side_fet <= 1'b0;
        end
      endcase
    end
  end

endmodule : bbc_bridge_ctrl
`default_nettype wire

// File: dv/bbc_bridge_ctrl_properties.sv
// checker: port relations of the bridge sequencer
// assumes a bind to bbc_bridge_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "bbc_consts.svh"
module bbc_bridge_ctrl_properties (
  input wire logic       clk,                     // clock
  input wire logic       rst_b,                   // reset
  input wire logic       bias_above_2v7,          // bias
  input wire logic       bias_above_3v8,          // bias
  input wire logic       adapter_sense_input_ok,  // adapter
  input wire logic       reverse_cmd_en,          // host enable
  input wire logic       single_cell,             // one cell
  input wire logic       turbo_event,             // turbo
  input wire logic       diode_emulation,         // light load
  input wire logic       phase_zero,              // phase zero
  input wire logic       adapter_switch_gate,     // switch
  input wire logic       config_current_en,       // pin current
  input wire logic       adapter_present_flag_oe, // flag low
  input wire logic       battery_path_gate,       // battery gate
  input wire logic       input_high_side_fet,     // gate
  input wire logic       input_low_side_fet,      // gate
  input wire logic       output_low_side_fet,     // gate
  input wire logic       output_high_side_fet     // gate
  ,input wire logic [2:0] bridge_mode             // mode
);
  // ****************
  // port relations
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  AST_FLAG_NO_ADP: assert property (!adapter_sense_input_ok |-> adapter_present_flag_oe)
    else $error("flag released without adapter");
  AST_FLAG_BIAS: assert property (!bias_above_3v8 |-> adapter_present_flag_oe)
    else $error("flag released with low bias");
  AST_FLAG_SWITCH: assert property (!adapter_switch_gate |-> adapter_present_flag_oe)
    else $error("flag released with switch off");
  // five cycles allow the mode and gate registers to drain
  AST_OFF_NO_FLAG: assert property ((adapter_present_flag_oe && !reverse_cmd_en)[*5] |->
    bridge_mode == `BBC_MODE_OFF && !(input_high_side_fet || input_low_side_fet || output_low_side_fet
    || output_high_side_fet))
    else $error("bridge active without flag");
  AST_NO_OVERLAP: assert property (!(input_high_side_fet && input_low_side_fet) &&
    !(output_high_side_fet && output_low_side_fet))
    else $error("pair shoot-through");
  AST_ONE_CELL: assert property (single_cell[*3] |-> !bridge_mode[2])
    else $error("reverse with one cell");
  AST_NO_CMD: assert property ((!reverse_cmd_en)[*3] |-> !bridge_mode[2])
    else $error("reverse without command");
  AST_TURBO: assert property (bias_above_2v7 |=> battery_path_gate == $past(turbo_event))
    else $error("battery gate not following turbo");
  AST_BIAS_IDLE: assert property ((!bias_above_2v7)[*2] |-> bridge_mode == `BBC_MODE_OFF
    && !adapter_switch_gate && adapter_present_flag_oe)
    else $error("active without bias");
  AST_CONFIG_RESISTOR_PIN_FIRST: assert property ($rose(adapter_switch_gate) |-> $past(config_current_en))
    else $error("switch on before config read");
  AST_BUCK_HOLD: assert property ((bridge_mode == `BBC_MODE_BUCK || bridge_mode == `BBC_MODE_RBOOST)[*8]
    |-> output_high_side_fet && !output_low_side_fet)
    else $error("output pair not held");
  AST_BOOST_HOLD: assert property ((bridge_mode == `BBC_MODE_BOOST || bridge_mode == `BBC_MODE_RBUCK)[*8]
    |-> input_high_side_fet && !input_low_side_fet)
    else $error("input pair not held");
  AST_DE_CUT: assert property (diode_emulation && phase_zero && bridge_mode == `BBC_MODE_BUCK
    |-> ##3 !input_low_side_fet)
    else $error("low side kept on past zero");
  cover property (bridge_mode == `BBC_MODE_BB);
  cover property (bridge_mode == `BBC_MODE_RBB);
  cover property ($fell(adapter_present_flag_oe));
endmodule : bbc_bridge_ctrl_properties
`default_nettype wire

// File: dv/bbc_bridge_model.sv
// far side: adapter switch, ripple comparators, phase node
// assumes the bench clock and reset; quick or slow switch
`timescale 1ns/1ps
`default_nettype none
module bbc_bridge_model (
  input  wire logic clk,                    // clock
  input  wire logic rst_b,                  // reset
  input  wire logic slow,                   // slow switch
  input  wire logic adapter_switch_gate,    // switch drive
  input  wire logic input_low_side_fet,     // low side
  input  wire logic output_low_side_fet,    // low side
  output logic      adapter_switch_on_done, // switch on
  output logic      ripple_at_window,       // top of window
  output logic      ripple_at_comp,         // back at comp
  output logic      phase_zero              // phase at zero
);
  logic [3:0] on_cnt_q;
  logic [3:0] rip_cnt_q;
  logic [1:0] low_cnt_q;
  // enhancement time; done drops at the next clock edge after drive goes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b || !adapter_switch_gate) begin
      on_cnt_q <= 4'h0;
    end else if (on_cnt_q != 4'hF) begin
      on_cnt_q <= on_cnt_q + 4'h1;
    end
  end
  assign adapter_switch_on_done = on_cnt_q >= (slow ? 4'hC : 4'h2);
  // fixed ripple: comp crossing, window crossing half way
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rip_cnt_q <= 4'h0;
    end else begin
      rip_cnt_q <= rip_cnt_q + 4'h1;
    end
  end
  assign ripple_at_comp = rip_cnt_q == 4'h0;
  assign ripple_at_window = rip_cnt_q == 4'h8;
  // phase reaches zero after three cycles of low side
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b || !(input_low_side_fet || output_low_side_fet)) begin
      low_cnt_q <= 2'h0;
    end else if (low_cnt_q != 2'h3) begin
      low_cnt_q <= low_cnt_q + 2'h1;
    end
  end
  assign phase_zero = low_cnt_q == 2'h3;
endmodule : bbc_bridge_model
`default_nettype wire

// File: dv/tb_top.sv
// bench: sequencer, far-side model, bound checker
// assumes shortened debounce and settle counts below
`timescale 1ns/1ps
`default_nettype none
`include "bbc_consts.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  localparam int unsigned DSHORT = 20;
  localparam int unsigned DLONG  = 50;
  localparam int unsigned SETTLE = 5;
  logic clk, rst_b, bias_above_2v7, bias_above_3v8, adapter_above_3v2, long_debounce_sel, slow;
  logic adapter_sense_input_ok, input_sense_node_ok, adapter_switch_on_done, adp_gt_94, adp_gt_120;
  logic adp_lt_106, adp_lt_80, reverse_cmd_en, reverse_power_enable_pin, battery_above_5v2, single_cell;
  logic turbo_event, ripple_at_window, ripple_at_comp, diode_emulation, phase_zero, adapter_switch_gate;
  logic config_current_en, adapter_present_flag_o, adapter_present_flag_oe, battery_path_gate;
  logic input_high_side_fet, input_low_side_fet, output_low_side_fet, output_high_side_fet, first_plug;
  logic [4:0]  config_code_in, config_code;
  logic [2:0]  bridge_mode, fwd_mode;
  logic [31:0] seed;
  int          miscompares, tests_run;
  int          corner[8] = '{106, 105, 80, 79, 94, 95, 120, 121};
  bbc_bridge_ctrl #(.DEB_LONG_CYC(DLONG), .DEB_SHORT_CYC(DSHORT), .SETTLE_CYC(SETTLE), .DEAD_CYC(3)) u_dut (
    .clk, .rst_b, .bias_above_2v7, .bias_above_3v8, .adapter_above_3v2, .adapter_sense_input_ok,
    .input_sense_node_ok, .long_debounce_sel, .adapter_switch_on_done, .config_code_in, .adp_gt_94,
    .adp_gt_120, .adp_lt_106, .adp_lt_80, .reverse_cmd_en, .reverse_power_enable_pin, .battery_above_5v2,
    .single_cell, .turbo_event, .ripple_at_window, .ripple_at_comp, .diode_emulation, .phase_zero,
    .adapter_switch_gate, .config_current_en, .config_code, .adapter_present_flag_o, .adapter_present_flag_oe,
    .battery_path_gate, .input_high_side_fet, .input_low_side_fet, .output_low_side_fet,
    .output_high_side_fet, .bridge_mode);
  bbc_bridge_model u_model (.*);
  always #4 clk = ~clk;
  // ****************
  // expectations
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr
  // hysteresis walked twice so two-step changes settle
  function automatic logic [2:0] fwd(input logic [2:0] m, input int r);
    logic [2:0] n;
    n = m;
    repeat (2) begin
      if (r > 120) n = `BBC_MODE_BUCK;
      else if (n == `BBC_MODE_BOOST && r > 94) n = `BBC_MODE_BB;
      else if (n == `BBC_MODE_BUCK && r < 106) n = `BBC_MODE_BB;
      else if (n == `BBC_MODE_BB && r < 80) n = `BBC_MODE_BOOST;
    end
    return n;
  endfunction : fwd
  function automatic logic [2:0] rmap(input logic [2:0] f);
    case (f)
      `BBC_MODE_BOOST: return `BBC_MODE_RBUCK;
      `BBC_MODE_BUCK:  return `BBC_MODE_RBOOST;
      default:         return `BBC_MODE_RBB;
    endcase
  endfunction : rmap
  // per gate {seen high, seen low}: input high side first, output high side last
  function automatic logic [7:0] gexp(input logic [2:0] m);
    case (m)
      `BBC_MODE_BUCK, `BBC_MODE_RBOOST: return 8'hF6;
      `BBC_MODE_BOOST, `BBC_MODE_RBUCK: return 8'h9F;
      `BBC_MODE_BB, `BBC_MODE_RBB:      return 8'hFF;
      default:                          return 8'h55;
    endcase
  endfunction : gexp
  task automatic ratio(input int r);
    adp_gt_94 <= r > 94;
    adp_gt_120 <= r > 120;
    adp_lt_106 <= r < 106;
    adp_lt_80 <= r < 80;
    fwd_mode = fwd(fwd_mode, r);
  endtask : ratio
  // plug in; gl is the cycle of a one-cycle input sense dip
  task automatic plug(input logic sel, input int gl);
    int          n;
    int unsigned dl;
    n = 0;
    dl = (first_plug || !sel) ? DSHORT : DLONG;
    seed = lfsr(seed);
    @(posedge clk);
    long_debounce_sel <= sel;
    config_code_in <= seed[4:0];
    slow <= seed[5];
    adapter_above_3v2 <= 1'b1;
    adapter_sense_input_ok <= 1'b1;
    ratio(130);
    while (config_current_en !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
      input_sense_node_ok <= (n != gl);
    end
    `CHK("debounce", 1'b1, n >= dl + gl && n <= dl + gl + 4)
    first_plug = 1'b0;
    repeat (SETTLE + 24) @(posedge clk);
    #1;
    `CHK("flag", 1'b0, adapter_present_flag_oe)
    `CHK("config", seed[4:0], config_code)
    `CHK("mode", `BBC_MODE_BUCK, bridge_mode)
  endtask : plug
  task automatic unplug();
    @(posedge clk);
    adapter_above_3v2 <= 1'b0;
    adapter_sense_input_ok <= 1'b0;
    reverse_cmd_en <= 1'b0;
    diode_emulation <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    `CHK("unplug flag", 1'b1, adapter_present_flag_oe)
    `CHK("unplug mode", `BBC_MODE_OFF, bridge_mode)
    `CHK("flag drive", 1'b0, adapter_present_flag_o)
  endtask : unplug
  // q is {command, pin, battery, one cell}
  task automatic step(input int r, input logic [3:0] q);
    logic [7:0] seen;
    logic [3:0] g;
    logic [2:0] m;
    seen = 8'h00;
    @(posedge clk);
    ratio(r);
    {reverse_cmd_en, reverse_power_enable_pin, battery_above_5v2, single_cell} <= q;
    turbo_event <= seed[12];
    m = (q[3:1] == 3'h7 && !q[0]) ? rmap(fwd_mode) : fwd_mode;
    repeat (20) @(posedge clk);
    #1;
    `CHK("mode", m, bridge_mode)
    `CHK("turbo", seed[12], battery_path_gate)
    repeat (48) begin
      @(posedge clk);
      #1;
      g = {input_high_side_fet, input_low_side_fet, output_low_side_fet, output_high_side_fet};
      for (int k = 0; k < 4; k++) seen[2*k +: 2] = seen[2*k +: 2] | {g[k], !g[k]};
    end
    `CHK("gates", gexp(m), seen)
  endtask : step
  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  // ****************
  // sequence
  // ****************
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {bias_above_2v7, bias_above_3v8, input_sense_node_ok} = 3'h7;
    {adapter_above_3v2, adapter_sense_input_ok, long_debounce_sel, slow, diode_emulation} = 5'h00;
    {adp_gt_94, adp_gt_120, adp_lt_106, adp_lt_80, turbo_event} = 5'h00;
    {reverse_cmd_en, reverse_power_enable_pin, battery_above_5v2, single_cell} = 4'h0;
    config_code_in = 5'h00;
    seed = 32'hE8C4CF1B;
    fwd_mode = `BBC_MODE_OFF;
    first_plug = 1'b1;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    plug(1'b1, 0);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      step(i < 8 ? corner[i] : 60 + int'(seed[6:0]) % 81,
           i < 8 ? 4'h0 : {|seed[8:7], |seed[10:9], |seed[14:13], &seed[17:15]});
    end
    diode_emulation <= 1'b1;
    step(130, 4'h0);
    unplug();
    plug(1'b1, 0);
    unplug();
    plug(1'b0, 10);
    @(posedge clk);
    bias_above_3v8 <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("low bias flag", 1'b1, adapter_present_flag_oe)
    bias_above_2v7 <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("bias off mode", `BBC_MODE_OFF, bridge_mode)
    `CHK("bias off gate", 1'b0, adapter_switch_gate)
    unplug();
    bias_above_2v7 <= 1'b1;
    bias_above_3v8 <= 1'b1;
    first_plug = 1'b1;
    plug(1'b1, 0);
    end_of_test();
  end
  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule : tb_top
bind bbc_bridge_ctrl bbc_bridge_ctrl_properties u_props (.*);
`default_nettype wire
